/* File: rtl/ahb_reg_slave.sv */
`timescale 1ns/10ps
module ahb_reg_slave
  import shared_timer_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       idx,
  output logic             hreadyout,
  output logic             hresp
);

  logic       wr_q, wr_d;
  logic       rd_q, rd_d;
  logic [7:0] idx_q, idx_d;
  logic       take;

  always_comb begin
    take  = ce && hsel && hready && htrans[1] && (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);
    wr_d  = take && hwrite;
    rd_d  = take && !hwrite;
    idx_d = take ? haddr[9:2] : idx_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      idx_q <= 8'h00;
    end else if (ce) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      idx_q <= idx_d;
    end
  end

  assign wr_en     = wr_q && ce;
  assign rd_en     = rd_q;
  assign idx       = idx_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : ahb_reg_slave

/* File: rtl/shared_prescaler.sv */
`timescale 1ns/10ps
module shared_prescaler
  import shared_timer_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic       bypass,
  input  wire logic [3:0] sel,
  output logic            out_tick
);

  // count is internal only: no read or load path exists
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] nxt;
  logic [7:0] last;

  always_comb begin
    nxt      = cnt_q + 8'h01;
    last     = 8'((9'h001 << sel) - 9'h001);
    cnt_d    = cnt_q;
    out_tick = 1'b0;
    if (clear) begin
      cnt_d = 8'h00;
    end else if (tick) begin
      if (bypass) begin
        out_tick = 1'b1;
      end else begin
        // sel n divides by 2**n (by 256 for any sel above 8), restarting from zero
        cnt_d = nxt;
        out_tick = (cnt_q == last);
        if (out_tick) begin
          cnt_d = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  AST_PRESC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && clear |=> cnt_q == 8'h00) else $error("prescaler not cleared");

endmodule : shared_prescaler

/* File: rtl/shared_timer_pkg.sv */
package shared_timer_pkg;

  // ==========================================================
  // register map (printed offsets 0x01, 0x0B, 0x81 are indices)
  // ==========================================================
  localparam logic [7:0] IDX_TIMER_COUNT   = 8'h01;
  localparam logic [7:0] IDX_INT_CONTROL   = 8'h0B;
  localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;
  localparam logic [7:0] IDX_WDOG_CLEAR    = 8'hC0;
  localparam logic [7:0] IDX_WDOG_COUNT    = 8'hC1;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'hC2;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'hC3;

  // ==========================================================
  // option_config fields
  // ==========================================================
  localparam int         OPT_SOURCE_BIT  = 5;
  localparam int         OPT_EDGE_BIT    = 4;
  localparam int         OPT_ASSIGN_BIT  = 3;
  localparam int         OPT_RATIO_LSB   = 0;
  localparam logic [7:0] OPT_RESET       = 8'hFF;

  // ==========================================================
  // int_control fields
  // ==========================================================
  localparam int         INT_TOV_EN_BIT   = 5;
  localparam int         INT_TOV_FLAG_BIT = 2;
  localparam logic [7:0] INT_RESET        = 8'h00;

  // ==========================================================
  // irq status bits
  // ==========================================================
  localparam int         IRQ_TOV_BIT  = 0;
  localparam int         IRQ_WDOG_BIT = 1;
  localparam logic [1:0] IRQ_RESET    = 2'h0;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         INSTR_CYC_NS   = 20;
  localparam int         QPHASES        = INSTR_CYC_NS / CLK_PERIOD_NS;
  localparam logic [1:0] Q2_PHASE       = 2'h1;
  localparam logic [1:0] Q4_PHASE       = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

endpackage : shared_timer_pkg

/* File: rtl/shared_timer_prescaler.sv */
// How it works
// - one prescaler, timer or watchdog only
// - prescaler count hidden, never loaded
// - owner and ratio from option bits 3:0
// - timer write clears prescaler when timer owns
// - watchdog clear resets watchdog, and prescaler when watchdog owns
// - timer write keeps assign and ratio
// - bit 5 picks external or instruction clock
// - bit 4 picks falling or rising edge
// - bit 3 set gives prescaler to watchdog
// - option bits read/write, reset to ones
// - overflow sets flag, enable bit masks
// - undivided internal mode counts each instruction cycle
// - timer write inhibits increments for two instruction cycles
// - prescaler output sampled at Q2 and Q4 when timer owns; watchdog takes it unsampled
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
module shared_timer_prescaler
  import shared_timer_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [2:0]  hburst,
  input  wire logic [3:0]  hprot,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_count_input,
  input  wire logic        watchdog_tick,
  output logic             irq,
  output logic             watchdog_timeout
);

  // ==========================================================
  // bus slave
  // ==========================================================
  logic       wr_en;
  logic [7:0] idx;
  logic       rd_take;
  logic [7:0] rd_idx;

  ahb_reg_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .wr_en     (wr_en),
    .rd_en     (),
    .idx       (idx),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_e;

  phase_e     ph_q, ph_d;
  logic [7:0] opt_q, opt_d;
  logic [7:0] tmr_q, tmr_d;
  logic [7:0] intc_q, intc_d;
  logic [7:0] wdog_q, wdog_d;
  logic [1:0] sts_q, sts_d;
  logic [1:0] msk_q, msk_d;
  logic [1:0] inh_q, inh_d;
  logic       ext_q, ext_d;
  logic       samp_q, samp_d;
  logic       latch_q, latch_d;
  logic [31:0] rdata_q, rdata_d;

  logic       instr_tick;
  logic       wdt_own;
  logic       ext_edge;
  logic       src_tick;
  logic       timer_in;
  logic       wdog_in;
  logic       presc_out;
  logic       presc_clear;
  logic       presc_in;
  logic       presc_bypass;
  logic [3:0] presc_sel;
  logic       tmr_wr;
  logic       wdclr;
  logic       tmr_inc;
  logic       tov;
  logic       wdov;
  logic       sample_ph;

  // ==========================================================
  // phase sequencer and source select
  // ==========================================================
  always_comb begin
    case (ph_q)
      PH_Q1:   ph_d = PH_Q2;
      PH_Q2:   ph_d = PH_Q3;
      PH_Q3:   ph_d = PH_Q4;
      PH_Q4:   ph_d = PH_Q1;
      default: ph_d = PH_Q1;
    endcase
    instr_tick = (ph_q == PH_Q4);
    sample_ph  = (ph_q == PH_Q2) || (ph_q == PH_Q4);
    ext_d      = ext_count_input;
    // edge select: 1 = falling, 0 = rising
    ext_edge   = opt_q[OPT_EDGE_BIT] ? (ext_q && !ext_count_input)
                                     : (!ext_q && ext_count_input);
    src_tick   = opt_q[OPT_SOURCE_BIT] ? ext_edge : instr_tick;
    wdt_own    = opt_q[OPT_ASSIGN_BIT];
    tmr_wr     = wr_en && hit(idx, IDX_TIMER_COUNT);
    wdclr      = wr_en && hit(idx, IDX_WDOG_CLEAR);
    // the owner alone passes through the divider
    presc_in     = wdt_own ? watchdog_tick : src_tick;
    presc_bypass = wdt_own && (opt_q[2:0] == 3'h0);
    presc_sel    = wdt_own ? {1'b0, opt_q[2:0]} : ({1'b0, opt_q[2:0]} + 4'h1);
    presc_clear  = wdt_own ? wdclr : tmr_wr;
  end

  shared_prescaler u_presc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .tick     (presc_in),
    .clear    (presc_clear),
    .bypass   (presc_bypass),
    .sel      (presc_sel),
    .out_tick (presc_out)
  );

  // ==========================================================
  // sync of divider output, timer, watchdog, registers
  // ==========================================================
  always_comb begin
    // divider output held until Q2/Q4 sample
    latch_d  = (latch_q || (!wdt_own && presc_out)) && !sample_ph;
    samp_d   = sample_ph && (latch_q || (!wdt_own && presc_out));
    timer_in = wdt_own ? src_tick : samp_q;
    wdog_in  = wdt_own ? presc_out : watchdog_tick;
    tmr_inc  = timer_in && (inh_q == 2'h0);
    tov      = tmr_inc && (tmr_q == 8'hFF);
    wdov     = wdog_in && (wdog_q == 8'hFF) && !wdclr;

    tmr_d  = tmr_inc ? tmr_q + 8'h01 : tmr_q;
    inh_d  = (inh_q != 2'h0 && instr_tick) ? inh_q - 2'h1 : inh_q;
    opt_d  = opt_q;
    intc_d = intc_q;
    msk_d  = msk_q;
    sts_d  = sts_q;
    wdog_d = wdclr ? 8'h00 : (wdog_in ? wdog_q + 8'h01 : wdog_q);

    if (tmr_wr) begin
      tmr_d = hwdata[7:0];
      inh_d = INHIBIT_CYCLES;
    end
    if (wr_en && hit(idx, IDX_OPTION_CONFIG)) begin
      opt_d = hwdata[7:0];
    end
    if (wr_en && hit(idx, IDX_INT_CONTROL)) begin
      intc_d = hwdata[7:0];
    end
    if (wr_en && hit(idx, IDX_IRQ_MASK)) begin
      msk_d = hwdata[1:0];
    end
    if (wr_en && hit(idx, IDX_IRQ_STATUS)) begin
      sts_d = sts_q & ~hwdata[1:0];
    end
    // hardware set wins over software clear
    if (tov) begin
      intc_d[INT_TOV_FLAG_BIT] = 1'b1;
      sts_d[IRQ_TOV_BIT]       = 1'b1;
    end
    if (wdov) begin
      sts_d[IRQ_WDOG_BIT] = 1'b1;
    end

    // read decoded in the address phase so hrdata stands in the data phase
    rd_take = ce && hsel && hready && htrans[1] && !hwrite && (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);
    rd_idx  = haddr[9:2];
    rdata_d = rdata_q;
    if (rd_take) begin
      case (1'b1)
        hit(rd_idx, IDX_TIMER_COUNT):   rdata_d = {24'h0, tmr_q};
        hit(rd_idx, IDX_INT_CONTROL):   rdata_d = {24'h0, intc_q};
        hit(rd_idx, IDX_OPTION_CONFIG): rdata_d = {24'h0, opt_q};
        hit(rd_idx, IDX_WDOG_COUNT):    rdata_d = {24'h0, wdog_q};
        hit(rd_idx, IDX_IRQ_STATUS):    rdata_d = {30'h0, sts_q};
        hit(rd_idx, IDX_IRQ_MASK):      rdata_d = {30'h0, msk_q};
        default:                     rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q    <= PH_Q1;
      opt_q   <= OPT_RESET;
      tmr_q   <= 8'h00;
      intc_q  <= INT_RESET;
      wdog_q  <= 8'h00;
      sts_q   <= IRQ_RESET;
      msk_q   <= IRQ_RESET;
      inh_q   <= 2'h0;
      ext_q   <= 1'b0;
      samp_q  <= 1'b0;
      latch_q <= 1'b0;
      rdata_q <= 32'h0;
    end else if (ce) begin
      ph_q    <= ph_d;
      opt_q   <= opt_d;
      tmr_q   <= tmr_d;
      intc_q  <= intc_d;
      wdog_q  <= wdog_d;
      sts_q   <= sts_d;
      msk_q   <= msk_d;
      inh_q   <= inh_d;
      ext_q   <= ext_d;
      samp_q  <= samp_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
    end
  end

  // read data loaded at the address phase, held until the next read
  assign hrdata           = rdata_q;
  assign irq              = (|(sts_q & msk_q)) ||
                            (intc_q[INT_TOV_FLAG_BIT] && intc_q[INT_TOV_EN_BIT]);
  assign watchdog_timeout = sts_q[IRQ_WDOG_BIT];

  // ==========================================================
  // checks
  // ==========================================================
  AST_OPT_RESET: assert property (@(posedge hclk) $rose(hresetn) |-> opt_q == 8'hFF)
    else $error("option reset value wrong");
  AST_TMR_WR_KEEPS_OPT: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tmr_wr && !hit(idx, IDX_OPTION_CONFIG) |=> $stable(opt_q)) else $error("option changed by timer write");
  AST_TMR_WR_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tmr_wr && !wdt_own |-> presc_clear) else $error("timer write left prescaler");
  AST_WDCLR: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wdclr |=> wdog_q == 8'h00) else $error("watchdog not cleared");
  AST_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tmr_wr |=> inh_q == 2'h2) else $error("inhibit not armed");
  AST_NO_INC_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
    inh_q != 2'h0 |-> !tmr_inc) else $error("timer ran while inhibited");
  AST_OVF_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tov |=> intc_q[INT_TOV_FLAG_BIT] && tmr_q == 8'h00) else $error("overflow flag missed");
  AST_SAMPLE_PHASE: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && samp_d |-> sample_ph) else $error("sampled outside Q2/Q4");
  AST_ONE_OWNER: assert property (@(posedge hclk) disable iff (!hresetn)
    wdt_own |-> timer_in == src_tick) else $error("timer divided while watchdog owns");
  COV_OVF:   cover property (@(posedge hclk) disable iff (!hresetn) tov);
  COV_WDCLR: cover property (@(posedge hclk) disable iff (!hresetn) wdclr && wdt_own);
  COV_EXT:   cover property (@(posedge hclk) disable iff (!hresetn) opt_q[OPT_SOURCE_BIT] && tmr_inc);

endmodule : shared_timer_prescaler

/* File: test/ext_pulse_src.sv */
`timescale 1ns/10ps
// ==========================================================
// external count source: n edges, each level held 8 clocks
// ==========================================================
module ext_pulse_src (
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [3:0] n_edges,
  output logic            pin,
  output logic            busy
);
  logic [3:0] left_q;
  logic [2:0] gap_q;

  initial begin
    pin    = 1'b0;
    left_q = 4'h0;
    gap_q  = 3'h0;
  end

  // line keeps its level between bursts, so edges are counted exactly
  always @(posedge hclk) begin
    if (go) begin
      left_q <= n_edges;
      gap_q  <= 3'h0;
    end else if (left_q != 4'h0) begin
      gap_q <= gap_q + 3'h1;
      if (gap_q == 3'h7) begin
        pin    <= ~pin;
        left_q <= left_q - 4'h1;
      end
    end
  end

  assign busy = (left_q != 4'h0);
endmodule // ext_pulse_src

/* File: test/tb_shared_timer_prescaler.sv */
`timescale 1ns/10ps
module tb_shared_timer_prescaler
  import shared_timer_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        ext_pin;
  logic        wd_tick;
  logic        irq;
  logic        go;
  logic [3:0]  n_edges;
  logic        busy;
  logic [7:0]  rv;
  int          n_errors;
  int          check_count;

  shared_timer_prescaler shared_timer_prescaler_i (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0), .hprot(4'h1),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .ext_count_input(ext_pin), .watchdog_tick(wd_tick),
    .irq(irq), .watchdog_timeout()
  );

  ext_pulse_src ext_pulse_src_i (
    .hclk(hclk), .go(go), .n_edges(n_edges), .pin(ext_pin), .busy(busy)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // ==========================================================
  // bus and checking tasks
  // ==========================================================
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_rdy();
    int t;
    t = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      t++;
      if (t > 50) begin
        n_errors++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask

  // read data is registered at the address-phase edge, taken just after the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] ix, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, ix, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // irq is combinational from registers: look once it has settled
  task automatic cmp_irq(input string nm, input logic exp);
    @(negedge hclk);
    cmp(nm, {7'h0, exp}, {7'h0, irq});
  endtask

  task automatic rate(input logic [7:0] opt, input int cyc, input logic [7:0] exp);
    logic [7:0] a;
    logic [7:0] b;
    ahb(1'b1, IDX_OPTION_CONFIG, opt, rv);
    ahb(1'b1, IDX_TIMER_COUNT, 8'h00, rv);
    repeat (16) @(posedge hclk);
    ahb(1'b0, IDX_TIMER_COUNT, 8'h00, a);
    // the read task itself spans three edges
    repeat (cyc - 3) @(posedge hclk);
    ahb(1'b0, IDX_TIMER_COUNT, 8'h00, b);
    cmp("timer rate", exp, b - a);
  endtask

  task automatic ext(input logic [3:0] n);
    int t;
    go      <= 1'b1;
    n_edges <= n;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    for (t = 0; busy === 1'b1; t++) begin
      if (t > 500) begin
        n_errors++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      wd_tick <= 1'b1;
      @(posedge hclk);
      wd_tick <= 1'b0;
      repeat (7) @(posedge hclk);
    end
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    wd_tick = 1'b0; go = 1'b0; n_edges = 4'h0;
    n_errors = 0; check_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;

    ahb(1'b0, IDX_OPTION_CONFIG, 8'h00, rv); cmp("option reset", 8'hFF, rv);
    ahb(1'b0, IDX_INT_CONTROL, 8'h00, rv); cmp("int_control reset", 8'h00, rv);
    ahb(1'b1, IDX_OPTION_CONFIG, 8'hA5, rv);
    ahb(1'b0, IDX_OPTION_CONFIG, 8'h00, rv); cmp("option rw", 8'hA5, rv);
    ahb(1'b1, 8'h30, 8'h5A, rv);
    ahb(1'b0, 8'h30, 8'h00, rv); cmp("unmapped", 8'h00, rv);
    $display("test registers done");

    rate(8'h08, 64, 8'h10);
    for (int n = 0; n < 8; n++) rate({5'h0, 3'(n)}, 32 << n, 8'h04);
    $display("test ratios done");

    repeat (512) @(posedge hclk);
    ahb(1'b1, IDX_TIMER_COUNT, 8'h10, rv);
    ahb(1'b0, IDX_OPTION_CONFIG, 8'h00, rv); cmp("option kept", 8'h07, rv);
    repeat (800) @(posedge hclk);
    ahb(1'b0, IDX_TIMER_COUNT, 8'h00, rv); cmp("prescaler cleared", 8'h10, rv);
    repeat (400) @(posedge hclk);
    ahb(1'b0, IDX_TIMER_COUNT, 8'h00, rv); cmp("full ratio", 8'h11, rv);
    ahb(1'b1, IDX_OPTION_CONFIG, 8'h08, rv);
    ahb(1'b1, IDX_TIMER_COUNT, 8'h20, rv);
    ahb(1'b0, IDX_TIMER_COUNT, 8'h00, rv); cmp("inhibit", 8'h20, rv);
    $display("test clear done");

    for (int e = 0; e < 2; e++) begin
      ahb(1'b1, IDX_OPTION_CONFIG, 8'h28 | 8'(e << 4), rv);
      ahb(1'b1, IDX_TIMER_COUNT, 8'h00, rv);
      repeat (16) @(posedge hclk);
      ext(4'h5);
      ahb(1'b0, IDX_TIMER_COUNT, 8'h00, rv); cmp("ext edges", 8'h03, rv);
    end
    $display("test external done");

    for (int c = 0; c < 3; c++) begin
      ahb(1'b1, IDX_WDOG_CLEAR, 8'h00, rv);
      ahb(1'b1, IDX_OPTION_CONFIG, 8'h08 | 8'(c), rv);
      ahb(1'b1, IDX_WDOG_CLEAR, 8'h00, rv);
      ticks(8);
      ahb(1'b0, IDX_WDOG_COUNT, 8'h00, rv); cmp("watchdog div", 8'(8 >> c), rv);
      ahb(1'b1, IDX_WDOG_CLEAR, 8'h00, rv);
      ahb(1'b0, IDX_WDOG_COUNT, 8'h00, rv); cmp("watchdog clear", 8'h00, rv);
    end
    $display("test watchdog done");

    ahb(1'b1, IDX_OPTION_CONFIG, 8'h08, rv);
    ahb(1'b1, IDX_INT_CONTROL, 8'h00, rv);
    ahb(1'b1, IDX_TIMER_COUNT, 8'hF0, rv);
    repeat (120) @(posedge hclk);
    ahb(1'b0, IDX_INT_CONTROL, 8'h00, rv); cmp("overflow flag", 8'h04, rv);
    cmp_irq("irq masked", 1'b0);
    ahb(1'b1, IDX_INT_CONTROL, 8'h24, rv);
    cmp_irq("irq enabled", 1'b1);
    ahb(1'b1, IDX_INT_CONTROL, 8'h20, rv);
    cmp_irq("irq flag cleared", 1'b0);
    ahb(1'b1, IDX_IRQ_MASK, 8'h01, rv);
    cmp_irq("irq status unmasked", 1'b1);
    ahb(1'b1, IDX_IRQ_STATUS, 8'h01, rv);
    ahb(1'b0, IDX_IRQ_STATUS, 8'h00, rv); cmp("status w1c", 8'h00, rv);
    cmp_irq("irq after w1c", 1'b0);
    $display("test interrupts done");
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    wrap_up();
  end
endmodule // tb_shared_timer_prescaler
